// ==== sdes_status.sv ====
// Purpose: Drop-event status register with two capture slots and mask
// Assumes: Drop cause inputs come from logic on SYS_CLK, valid with DROP_EVENT
// Notes:   Status clears on read; event coinciding with a read is kept
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps

module sdes_status
  import sdes_pkg::*;
(
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  // Register port
  input  wire logic [15:0] REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  // Drop event and source port
  input  wire logic        DROP_EVENT,
  input  wire logic [1:0]  DROP_SRC_PORT,
  // Drop causes
  input  wire logic        VID_ALL_ONES,
  input  wire logic        TAGGED_ONLY_ADMISSION,
  input  wire logic        PKT_UNTAGGED,
  input  wire logic        BCAST_THROTTLED,
  input  wire logic        DA_FOUND,
  input  wire logic        DA_BROADCAST,
  input  wire logic        DA_MULTICAST,
  input  wire logic        MEMBER_CHECK_EN,
  input  wire logic        NONMEMBER_ADMIT,
  input  wire logic        SRC_MEMBER,
  input  wire logic        DST_MEMBER,
  input  wire logic        SRC_FORWARDING,
  input  wire logic        DST_FORWARDING,
  input  wire logic        SAME_PORT,
  input  wire logic        ADDR_FILTER,
  input  wire logic        UNKNOWN_UCAST_DISCARD,
  input  wire logic        UNKNOWN_MCAST_FILTER,
  // Switch interrupt
  output logic             SWITCH_IRQ
);

  // Status and mask state
  logic       mask_reg;
  logic       mask_next;
  logic       pend_reg;
  logic       pend_next;
  logic       a_val_reg;
  logic       a_val_next;
  logic [3:0] a_code_reg;
  logic [3:0] a_code_next;
  logic [1:0] a_port_reg;
  logic [1:0] a_port_next;
  logic       b_val_reg;
  logic       b_val_next;
  logic [3:0] b_code_reg;
  logic [3:0] b_code_next;
  logic [1:0] b_port_reg;
  logic [1:0] b_port_next;
  logic [31:0] rdata_next;
  logic       irq_next;

  // Address decode
  wire sel_mask = (REG_ADDR == SDES_MASK_ADDR);
  wire sel_stat = (REG_ADDR == SDES_STAT_ADDR);
  wire wr_mask  = REG_WR & sel_mask;
  wire rd_stat  = REG_RD & sel_stat;

  // Cause decode
  wire da_unknown = ~DA_FOUND;
  wire unk_or_bc  = da_unknown | DA_BROADCAST;
  wire known      = DA_FOUND & ~DA_BROADCAST;

  wire c_vid   = VID_ALL_ONES;
  wire c_tag   = TAGGED_ONLY_ADMISSION & PKT_UNTAGGED;
  wire c_bcth  = DA_BROADCAST & BCAST_THROTTLED;
  wire c_unfw  = unk_or_bc & ~SRC_FORWARDING;
  wire c_unsm  = unk_or_bc & MEMBER_CHECK_EN & ~NONMEMBER_ADMIT
                 & ~SRC_MEMBER;
  wire c_ucst  = UNKNOWN_UCAST_DISCARD & da_unknown
                 & ~DA_MULTICAST & ~DA_BROADCAST;
  wire c_mcst  = UNKNOWN_MCAST_FILTER & da_unknown
                 & DA_MULTICAST & ~DA_BROADCAST;
  wire c_filt  = known & ADDR_FILTER;
  wire c_same  = known & SAME_PORT;
  wire c_sfwd  = known & ~SRC_FORWARDING;
  wire c_dfwd  = known & ~DST_FORWARDING;
  wire c_smem  = known & MEMBER_CHECK_EN & ~NONMEMBER_ADMIT
                 & ~SRC_MEMBER;
  wire c_dmem  = known & MEMBER_CHECK_EN & ~DST_MEMBER;

  // Priority selection; reserved codes never produced
  wire [3:0] cause_code =
    c_vid  ? SDES_C_VID_ALL1  :
    c_tag  ? SDES_C_TAG_ONLY  :
    c_bcth ? SDES_C_BC_THROT  :
    c_unfw ? SDES_C_UNK_NFWD  :
    c_unsm ? SDES_C_UNK_SMEM  :
    c_ucst ? SDES_C_UNK_UCAST :
    c_mcst ? SDES_C_UNK_MCAST :
    c_filt ? SDES_C_ADDR_FILT :
    c_same ? SDES_C_SAME_PORT :
    c_sfwd ? SDES_C_SRC_NFWD  :
    c_dfwd ? SDES_C_DST_NFWD  :
    c_smem ? SDES_C_SRC_NMEM  :
             SDES_C_DST_NMEM;

  wire cause_hit = c_vid | c_tag | c_bcth | c_unfw | c_unsm | c_ucst | c_mcst
                   | c_filt | c_same | c_sfwd | c_dfwd | c_smem | c_dmem;
  wire evt       = DROP_EVENT & cause_hit;

  // Slot occupancy as seen after any read-clear in this cycle
  wire a_held = a_val_reg & ~rd_stat;
  wire b_held = b_val_reg & ~rd_stat;
  wire to_a   = evt & ~a_held;
  wire to_b   = evt & a_held & ~b_held;

  // Status word image
  wire [31:0] stat_word = {{SDES_RSVD_W{1'b0}},
                           b_code_reg,
                           b_port_reg,
                           b_val_reg,
                           a_code_reg,
                           a_port_reg,
                           a_val_reg,
                           pend_reg};
  wire [31:0] mask_word = {31'h0, mask_reg};

  // Next-state logic: read clears, a new event wins over the clear
  assign mask_next   = wr_mask ? REG_WDATA[0] : mask_reg;
  assign pend_next   = evt | (pend_reg & ~rd_stat);
  assign a_val_next  = to_a | a_held;
  assign a_code_next = to_a ? cause_code :
                       (a_held ? a_code_reg : SDES_CODE_RST);
  assign a_port_next = to_a ? DROP_SRC_PORT :
                       (a_held ? a_port_reg : SDES_PORT_RST);
  assign b_val_next  = to_b | b_held;
  assign b_code_next = to_b ? cause_code :
                       (b_held ? b_code_reg : SDES_CODE_RST);
  assign b_port_next = to_b ? DROP_SRC_PORT :
                       (b_held ? b_port_reg : SDES_PORT_RST);

  // Read data, one cycle after the read strobe
  assign rdata_next = ~REG_RD  ? 32'h0     :
                      sel_stat ? stat_word :
                      sel_mask ? mask_word : 32'h0;

  // Interrupt follows pending, gated by mask; status untouched
  assign irq_next = pend_next & ~mask_next;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      mask_reg   <= SDES_MASK_RST;
      pend_reg   <= 1'b0;
      a_val_reg  <= 1'b0;
      a_code_reg <= SDES_CODE_RST;
      a_port_reg <= SDES_PORT_RST;
      b_val_reg  <= 1'b0;
      b_code_reg <= SDES_CODE_RST;
      b_port_reg <= SDES_PORT_RST;
    end else begin
      mask_reg   <= mask_next;
      pend_reg   <= pend_next;
      a_val_reg  <= a_val_next;
      a_code_reg <= a_code_next;
      a_port_reg <= a_port_next;
      b_val_reg  <= b_val_next;
      b_code_reg <= b_code_next;
      b_port_reg <= b_port_next;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA  <= 32'h0;
      SWITCH_IRQ <= 1'b0;
    end else begin
      REG_RDATA  <= rdata_next;
      SWITCH_IRQ <= irq_next;
    end
  end

endmodule

// ==== sdes_pkg.sv ====
// Purpose: Constants for the switch drop-event status register bank
// Assumes: Register numbers are used directly as addresses on the plain port
// Notes:   Codes are the drop-reason encodings shared by both capture slots
package sdes_pkg;

  // Register numbers
  localparam logic [15:0] SDES_MASK_ADDR = 16'h1880;
  localparam logic [15:0] SDES_STAT_ADDR = 16'h1881;

  // Field widths and reset values
  localparam int          SDES_RSVD_W    = 17;
  localparam logic        SDES_MASK_RST  = 1'h1;
  localparam logic [3:0]  SDES_CODE_RST  = 4'h0;
  localparam logic [1:0]  SDES_PORT_RST  = 2'h0;

  // Drop-reason codes
  localparam logic [3:0]  SDES_C_TAG_ONLY  = 4'h0;
  localparam logic [3:0]  SDES_C_UNK_SMEM  = 4'h1;
  localparam logic [3:0]  SDES_C_SRC_NFWD  = 4'h2;
  localparam logic [3:0]  SDES_C_DST_NFWD  = 4'h3;
  localparam logic [3:0]  SDES_C_DST_NMEM  = 4'h4;
  localparam logic [3:0]  SDES_C_SRC_NMEM  = 4'h5;
  localparam logic [3:0]  SDES_C_UNK_UCAST = 4'h6;
  localparam logic [3:0]  SDES_C_UNK_MCAST = 4'h7;
  localparam logic [3:0]  SDES_C_BC_THROT  = 4'h8;
  localparam logic [3:0]  SDES_C_UNK_NFWD  = 4'h9;
  localparam logic [3:0]  SDES_C_SAME_PORT = 4'ha;
  localparam logic [3:0]  SDES_C_ADDR_FILT = 4'hb;
  localparam logic [3:0]  SDES_C_VID_ALL1  = 4'he;

endpackage

// ==== sdes_status_assertions.sv ====
// Purpose: Port assertions for the drop-event status register
// Assumes: Register strobes are one cycle and never together
// Notes:   Mask state is not modelled; checks tie outputs to strobes
`timescale 1ns/100ps
module sdes_status_chk
  import sdes_pkg::*;
(
  // Clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RST,
  // Register port
  input wire logic [15:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA,
  // Event and interrupt
  input wire logic        DROP_EVENT,
  input wire logic        SWITCH_IRQ
);
  wire rd_st = REG_RD && REG_ADDR == SDES_STAT_ADDR;
  wire rd_mk = REG_RD && REG_ADDR == SDES_MASK_ADDR;
  wire mk_on = REG_WR && REG_ADDR == SDES_MASK_ADDR && REG_WDATA[0];
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  rsvd_zero_a: assert property (REG_RDATA[31:15] == 17'h0)
    else $error("reserved status bits set");
  unmapped_rd_a: assert property (REG_RD && !rd_st && !rd_mk |=> REG_RDATA == 32'h0)
    else $error("unmapped read not zero");
  mask_bits_a: assert property (rd_mk |=> REG_RDATA[31:1] == 31'h0)
    else $error("mask upper bits set");
  clear_read_a: assert property (rd_st && !DROP_EVENT ##1 !DROP_EVENT ##1 rd_st
    |=> REG_RDATA[14:0] == 15'h0) else $error("status not cleared by read");
  irq_read_a: assert property (rd_st && !DROP_EVENT |=> !SWITCH_IRQ)
    else $error("interrupt after status read");
  irq_mask_a: assert property (mk_on |=> !SWITCH_IRQ)
    else $error("interrupt while masked");
  irq_hold_a: assert property (SWITCH_IRQ && !rd_st && !mk_on |=> SWITCH_IRQ)
    else $error("interrupt dropped without read");
  irq_cause_a: assert property ($rose(SWITCH_IRQ) |-> $past(DROP_EVENT) || $past(REG_WR))
    else $error("interrupt without cause");
  slot_order_a: assert property (REG_RDATA[8] |-> REG_RDATA[1:0] == 2'h3)
    else $error("slot B valid without slot A");
  cover property (rd_st && DROP_EVENT);
  cover property (REG_RDATA[8]);
  cover property ($rose(SWITCH_IRQ));
endmodule

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the drop-event status register
// Assumes: Causes are held steady with each drop pulse
// Notes:   Slot B codes and ports come from an LFSR seeded at 31
`timescale 1ns/100ps
module tb_top;
  import sdes_pkg::*;
  localparam logic [16:0] CV [13] = '{17'h100f0, 17'h0c0f0, 17'h028f0, 17'h008d0,
    17'h00a70, 17'h000f2, 17'h004f1, 17'h010f4, 17'h010f8,
    17'h010d0, 17'h010e0, 17'h01270, 17'h012b0};
  localparam logic [3:0] CC [13] = '{4'he, 4'h0, 4'h8, 4'h9, 4'h1, 4'h6, 4'h7, 4'hb, 4'ha,
    4'h2, 4'h3, 4'h5, 4'h4};
  logic        clk = 0, rst = 1, wr = 0, rd = 0, ev = 0, irq;
  logic [15:0] addr = 16'h0, r = 16'h001f;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [16:0] c = 17'h0;
  logic [1:0]  sp = 2'h0, pa, pb;
  int          errors = 0, checked = 0, cyc = 0, b;
  sdes_status uut (.SYS_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .DROP_EVENT(ev), .DROP_SRC_PORT(sp), .VID_ALL_ONES(c[16]),
    .TAGGED_ONLY_ADMISSION(c[15]), .PKT_UNTAGGED(c[14]), .BCAST_THROTTLED(c[13]),
    .DA_FOUND(c[12]), .DA_BROADCAST(c[11]), .DA_MULTICAST(c[10]), .MEMBER_CHECK_EN(c[9]),
    .NONMEMBER_ADMIT(c[8]), .SRC_MEMBER(c[7]), .DST_MEMBER(c[6]), .SRC_FORWARDING(c[5]),
    .DST_FORWARDING(c[4]), .SAME_PORT(c[3]), .ADDR_FILTER(c[2]),
    .UNKNOWN_UCAST_DISCARD(c[1]), .UNKNOWN_MCAST_FILTER(c[0]), .SWITCH_IRQ(irq));
  function automatic logic [15:0] nxt(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [31:0] stat(logic [3:0] ac, logic [1:0] ap, logic bv,
    logic [3:0] bc, logic [1:0] bp);
    return {17'h0, bv ? {bc, bp, 1'h1} : 7'h0, ac, ap, 2'h3};
  endfunction
  task automatic end_of_test();
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_irq(logic exp);
    checked++;
    if (irq !== exp) begin
      errors++;
      $display("BAD %0t interrupt %b", $time, irq);
    end
  endtask
  task automatic bus(logic w, logic [15:0] a, logic [31:0] v);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'h0;
    rd <= 1'h0;
    #1 d = rdata;
  endtask
  task automatic drop(int i, logic [1:0] p);
    @(posedge clk);
    ev <= 1'h1;
    c <= (i < 13) ? CV[i] : 17'h000f0;
    sp <= p;
    @(posedge clk);
    ev <= 1'h0;
    #1;
  endtask
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      errors = errors + 1;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    bus(0, SDES_MASK_ADDR, 0); chk(d, 32'h1);
    bus(1, SDES_STAT_ADDR, 32'hffffffff);
    bus(0, 16'h1882, 0); chk(d, 32'h0);
    drop(13, 2'h1);
    bus(0, SDES_STAT_ADDR, 0); chk(d, 32'h0);
    drop(0, 2'h2); chk_irq(1'h0);
    bus(1, SDES_MASK_ADDR, 0); chk_irq(1'h1);
    bus(0, SDES_STAT_ADDR, 0); chk(d, stat(CC[0], 2'h2, 0, 0, 0));
    for (int i = 0; i < 13; i++) begin
      r = nxt(r);
      b = r % 13;
      pa = r[9:8] % 3;
      pb = r[11:10] % 3;
      drop(i, pa); chk_irq(1'h1);
      drop(b, pb);
      if (r[4]) drop(r[7:4] % 13, 2'h1);
      bus(0, SDES_STAT_ADDR, 0); chk(d, stat(CC[i], pa, 1, CC[b], pb));
    end
    bus(0, SDES_STAT_ADDR, 0); chk(d, 32'h0);
    drop(3, 2'h2);
    fork
      bus(0, SDES_STAT_ADDR, 0);
      drop(5, 2'h0);
    join
    chk(d, stat(CC[3], 2'h2, 0, 0, 0));
    bus(0, SDES_STAT_ADDR, 0); chk(d, stat(CC[5], 2'h0, 0, 0, 0));
    drop(6, 2'h1);
    bus(1, SDES_MASK_ADDR, 1); chk_irq(1'h0);
    bus(0, SDES_STAT_ADDR, 0); chk(d, stat(CC[6], 2'h1, 0, 0, 0));
    end_of_test();
  end
endmodule
bind sdes_status sdes_status_chk chk (.SYS_CLK(SYS_CLK), .RST(RST), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .DROP_EVENT(DROP_EVENT), .SWITCH_IRQ(SWITCH_IRQ));
